// ---- iosd_pkg.sv ----
// constants, types and register map for the i/o status led display
//
// Behaviour
// - each 4-bit nibble becomes one hex digit; ten to fifteen show A b C d E F
// - segment mode: lowest digit segments a-e follow forward, reverse, three multipurpose inputs
// - segment mode: third digit segment a follows the transistor output contact
// - segment mode: fourth digit segment a lit while relay common meets normally-open
// - segment mode: all terminal inputs off shows segment g on all four digits
// - hex mode: 16-bit word, unassigned bits zero, top nibble on fourth digit
// - input word: forward bit 0, reverse bit 1, multipurpose inputs bits 2 to 4
// - comm forward, reverse, alarm reset at bits 13-15; second digit f, g, dp
// - output word: transistor output at bit 0, one when closed
// - output word: relay contact at bit 8, one when common meets normally-open
// - under communication control commanded inputs show uninverted, original command signals
// - item 0 terminals, 1 comm status, 2-4 voltage, current, meter readings
// - running mode after power-on; i/o check only at full-menu level
`default_nettype none
package iosd_pkg;

  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ITEM = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_IN_WORD = 8'h0c;
  localparam logic [7:0] REG_OUT_WORD = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CTRL_HEX_BIT = 0;
  localparam int CTRL_OUTSEL_BIT = 1;
  localparam int CTRL_LEVEL_LSB = 4;
  localparam int CMD_FWD_BIT = 0;
  localparam int CMD_REV_BIT = 1;
  localparam int CMD_X1_BIT = 2;
  localparam int CMD_X3_BIT = 4;
  localparam int CMD_XF_BIT = 5;
  localparam int CMD_XR_BIT = 6;
  localparam int CMD_RST_BIT = 7;
  localparam int WORD_XF_BIT = 13;
  localparam int WORD_XR_BIT = 14;
  localparam int WORD_RST_BIT = 15;
  localparam int WORD_RELAY_BIT = 8;
  localparam int WORD_TRANS_BIT = 0;
  localparam int SEG_G_BIT = 6;
  localparam int SEG_DP_BIT = 7;
  localparam int SEG_F_BIT = 5;

  // -------------------------------------------------------------
  // reset values and codes
  // -------------------------------------------------------------
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [1:0] LEVEL_FULL = 2'h2;
  localparam logic [2:0] ITEM_TERMINAL = 3'h0;
  localparam logic [2:0] ITEM_COMM = 3'h1;
  localparam logic [2:0] ITEM_VOLTAGE = 3'h2;
  localparam logic [2:0] ITEM_CURRENT = 3'h3;
  localparam logic [2:0] ITEM_METER = 3'h4;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] SEG_DARK = 8'h00;
  localparam logic [7:0] SEG_DASH = 8'h40;
  localparam logic [7:0] SEG_UNDERSCORE = 8'h08;
  localparam logic [3:0] MENU_NUMBER = 4'h4;

  // -------------------------------------------------------------
  // keypad state
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUNNING,
    ST_IO_LIST,
    ST_IO_SHOW
  } iosd_state_e;

endpackage
`default_nettype wire

// ---- iosd_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module iosd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// ---- iosd_hex_digits.sv ----
// splits a 16-bit word into four seven-segment hex glyphs
`timescale 1ns/1ps
`default_nettype none
module iosd_hex_digits (
  input wire logic [15:0] word,
  output logic [7:0] digit1,
  output logic [7:0] digit2,
  output logic [7:0] digit3,
  output logic [7:0] digit4
);

  // segment order dp g f e d c b a, high is lit
  function automatic logic [7:0] glyph(input logic [3:0] nib);
    logic [7:0] seg;
    seg = 8'h00;
    case (nib)
      4'h0: seg = 8'h3f;
      4'h1: seg = 8'h06;
      4'h2: seg = 8'h5b;
      4'h3: seg = 8'h4f;
      4'h4: seg = 8'h66;
      4'h5: seg = 8'h6d;
      4'h6: seg = 8'h7d;
      4'h7: seg = 8'h07;
      4'h8: seg = 8'h7f;
      4'h9: seg = 8'h6f;
      4'ha: seg = 8'h77;
      4'hb: seg = 8'h7c;
      4'hc: seg = 8'h39;
      4'hd: seg = 8'h5e;
      4'he: seg = 8'h79;
      4'hf: seg = 8'h71;
      default: seg = 8'h00;
    endcase
    return seg;
  endfunction

  assign digit1 = glyph(word[3:0]);
  assign digit2 = glyph(word[7:4]);
  assign digit3 = glyph(word[11:8]);
  assign digit4 = glyph(word[15:12]);

endmodule
`default_nettype wire

// ---- iosd_display.sv ----
// i/o check status word builder and four-digit led driver
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module iosd_display (
  input wire logic mclk,
  input wire logic rst,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic multipurpose_input_1,
  input wire logic multipurpose_input_2,
  input wire logic multipurpose_input_3,
  input wire logic transistor_output,
  input wire logic relay_contact_output,
  input wire logic key_program,
  input wire logic key_function,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic [15:0] voltage_input_word,
  input wire logic [15:0] current_input_word,
  input wire logic [15:0] meter_output_word,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [7:0] led_digit1,
  output logic [7:0] led_digit2,
  output logic [7:0] led_digit3,
  output logic [7:0] led_digit4
);

  // -------------------------------------------------------------
  // pin synchronisation
  // -------------------------------------------------------------
  logic [10:0] pins_sync;

  iosd_sync #(.WIDTH(11)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({key_down, key_up, key_function, key_program,
               relay_contact_output, transistor_output,
               multipurpose_input_3, multipurpose_input_2, multipurpose_input_1,
               reverse_run_input, forward_run_input}),
    .sync_out(pins_sync)
  );

  logic [4:0] term_in;
  logic trans_s;
  logic relay_s;
  logic [3:0] keys_s;
  assign term_in = pins_sync[4:0];
  assign trans_s = pins_sync[5];
  assign relay_s = pins_sync[6];
  assign keys_s = pins_sync[10:7];

  // -------------------------------------------------------------
  // key edge detection
  // -------------------------------------------------------------
  logic [3:0] keys_prev_r;
  logic [3:0] keys_prev_nxt;
  logic [3:0] key_press;

  always_comb begin
    keys_prev_nxt = keys_s;
    key_press = keys_s & ~keys_prev_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keys_prev_r <= 4'h0;
    end else begin
      keys_prev_r <= keys_prev_nxt;
    end
  end

  // -------------------------------------------------------------
  // registers and keypad state
  // -------------------------------------------------------------
  logic disp_hex_r;
  logic disp_hex_nxt;
  logic out_sel_r;
  logic out_sel_nxt;
  logic [1:0] level_r;
  logic [1:0] level_nxt;
  logic [2:0] item_r;
  logic [2:0] item_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  iosd_pkg::iosd_state_e state_r;
  iosd_pkg::iosd_state_e state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] in_word;
  logic [15:0] out_word;

  always_comb begin
    disp_hex_nxt = disp_hex_r;
    out_sel_nxt = out_sel_r;
    level_nxt = level_r;
    item_nxt = item_r;
    cmd_nxt = cmd_r;
    state_nxt = state_r;
    case (state_r)
      iosd_pkg::ST_RUNNING: begin
        if (key_press[0] && level_r == iosd_pkg::LEVEL_FULL) begin
          state_nxt = iosd_pkg::ST_IO_LIST;
        end
      end
      iosd_pkg::ST_IO_LIST: begin
        if (key_press[0]) begin
          state_nxt = iosd_pkg::ST_RUNNING;
        end else if (key_press[1]) begin
          state_nxt = iosd_pkg::ST_IO_SHOW;
        end else if (key_press[2]) begin
          item_nxt = (item_r == iosd_pkg::ITEM_METER) ? iosd_pkg::ITEM_TERMINAL : item_r + 3'h1;
        end else if (key_press[3]) begin
          item_nxt = (item_r == iosd_pkg::ITEM_TERMINAL) ? iosd_pkg::ITEM_METER : item_r - 3'h1;
        end
      end
      iosd_pkg::ST_IO_SHOW: begin
        if (key_press[0] || key_press[1]) begin
          state_nxt = iosd_pkg::ST_IO_LIST;
        end
      end
      default: state_nxt = iosd_pkg::ST_RUNNING;
    endcase
    // leaving full-menu level drops back to running
    if (level_r != iosd_pkg::LEVEL_FULL) begin
      state_nxt = iosd_pkg::ST_RUNNING;
    end
    if (reg_write) begin
      case (reg_addr)
        iosd_pkg::REG_CTRL: begin
          disp_hex_nxt = reg_wdata[iosd_pkg::CTRL_HEX_BIT];
          out_sel_nxt = reg_wdata[iosd_pkg::CTRL_OUTSEL_BIT];
          level_nxt = reg_wdata[iosd_pkg::CTRL_LEVEL_LSB +: 2];
        end
        iosd_pkg::REG_ITEM: begin
          if (reg_wdata[2:0] <= iosd_pkg::ITEM_METER) begin
            item_nxt = reg_wdata[2:0];
          end
        end
        iosd_pkg::REG_CMD: cmd_nxt = reg_wdata[7:0];
        default: cmd_nxt = cmd_r;
      endcase
    end
    rdata_nxt = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        iosd_pkg::REG_CTRL: rdata_nxt = {26'h000_0000, level_r, 2'h0, out_sel_r, disp_hex_r};
        iosd_pkg::REG_ITEM: rdata_nxt = {29'h0000_0000, item_r};
        iosd_pkg::REG_CMD: rdata_nxt = {24'h00_0000, cmd_r};
        iosd_pkg::REG_IN_WORD: rdata_nxt = {16'h0000, in_word};
        iosd_pkg::REG_OUT_WORD: rdata_nxt = {16'h0000, out_word};
        iosd_pkg::REG_STATE: rdata_nxt = {30'h0000_0000, state_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      disp_hex_r <= 1'b0;
      out_sel_r <= 1'b0;
      level_r <= iosd_pkg::LEVEL_RESET;
      item_r <= iosd_pkg::ITEM_TERMINAL;
      cmd_r <= iosd_pkg::CMD_RESET;
      state_r <= iosd_pkg::ST_RUNNING;
      rdata_r <= 32'h0000_0000;
    end else begin
      disp_hex_r <= disp_hex_nxt;
      out_sel_r <= out_sel_nxt;
      level_r <= level_nxt;
      item_r <= item_nxt;
      cmd_r <= cmd_nxt;
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // -------------------------------------------------------------
  // status words
  // -------------------------------------------------------------
  logic comm_mode;
  logic [4:0] shown_in;
  logic [2:0] comm_only;

  always_comb begin
    comm_mode = (item_r == iosd_pkg::ITEM_COMM);
    // commanded inputs taken straight from the command bits, no inversion
    shown_in = comm_mode ? cmd_r[iosd_pkg::CMD_X3_BIT:iosd_pkg::CMD_FWD_BIT] : term_in;
    comm_only = comm_mode ? {cmd_r[iosd_pkg::CMD_RST_BIT], cmd_r[iosd_pkg::CMD_XR_BIT],
                             cmd_r[iosd_pkg::CMD_XF_BIT]} : 3'h0;
    in_word = 16'h0000;
    in_word[4:0] = shown_in;
    in_word[iosd_pkg::WORD_XF_BIT] = comm_only[0];
    in_word[iosd_pkg::WORD_XR_BIT] = comm_only[1];
    in_word[iosd_pkg::WORD_RST_BIT] = comm_only[2];
    out_word = 16'h0000;
    out_word[iosd_pkg::WORD_TRANS_BIT] = trans_s;
    out_word[iosd_pkg::WORD_RELAY_BIT] = relay_s;
  end

  // -------------------------------------------------------------
  // digit selection
  // -------------------------------------------------------------
  logic [15:0] hex_word;
  logic [7:0] hex1;
  logic [7:0] hex2;
  logic [7:0] hex3;
  logic [7:0] hex4;

  always_comb begin
    case (item_r)
      iosd_pkg::ITEM_VOLTAGE: hex_word = voltage_input_word;
      iosd_pkg::ITEM_CURRENT: hex_word = current_input_word;
      iosd_pkg::ITEM_METER: hex_word = meter_output_word;
      default: hex_word = out_sel_r ? out_word : in_word;
    endcase
    if (state_r == iosd_pkg::ST_IO_LIST) begin
      hex_word = {iosd_pkg::MENU_NUMBER, 9'h000, item_r};
    end
  end

  iosd_hex_digits u_hex (
    .word(hex_word),
    .digit1(hex1),
    .digit2(hex2),
    .digit3(hex3),
    .digit4(hex4)
  );

  logic [7:0] seg1_r;
  logic [7:0] seg2_r;
  logic [7:0] seg3_r;
  logic [7:0] seg4_r;
  logic [7:0] seg1_nxt;
  logic [7:0] seg2_nxt;
  logic [7:0] seg3_nxt;
  logic [7:0] seg4_nxt;

  always_comb begin
    seg1_nxt = iosd_pkg::SEG_DARK;
    seg2_nxt = iosd_pkg::SEG_DARK;
    seg3_nxt = iosd_pkg::SEG_DARK;
    seg4_nxt = iosd_pkg::SEG_DARK;
    case (state_r)
      iosd_pkg::ST_IO_LIST: begin
        seg1_nxt = hex1;
        seg2_nxt = hex2;
        seg3_nxt = iosd_pkg::SEG_UNDERSCORE;
        seg4_nxt = hex4;
      end
      iosd_pkg::ST_IO_SHOW: begin
        if (item_r > iosd_pkg::ITEM_COMM || disp_hex_r) begin
          seg1_nxt = hex1;
          seg2_nxt = hex2;
          seg3_nxt = hex3;
          seg4_nxt = hex4;
        end else if (shown_in == 5'h00 && comm_only == 3'h0) begin
          seg1_nxt = iosd_pkg::SEG_DASH;
          seg2_nxt = iosd_pkg::SEG_DASH;
          seg3_nxt = iosd_pkg::SEG_DASH;
          seg4_nxt = iosd_pkg::SEG_DASH;
        end else begin
          seg1_nxt = {3'h0, shown_in};
          seg2_nxt[iosd_pkg::SEG_F_BIT] = comm_only[0];
          seg2_nxt[iosd_pkg::SEG_G_BIT] = comm_only[1];
          seg2_nxt[iosd_pkg::SEG_DP_BIT] = comm_only[2];
          seg3_nxt[0] = trans_s;
          seg4_nxt[0] = relay_s;
        end
      end
      default: seg1_nxt = iosd_pkg::SEG_DARK;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seg1_r <= iosd_pkg::SEG_DARK;
      seg2_r <= iosd_pkg::SEG_DARK;
      seg3_r <= iosd_pkg::SEG_DARK;
      seg4_r <= iosd_pkg::SEG_DARK;
    end else begin
      seg1_r <= seg1_nxt;
      seg2_r <= seg2_nxt;
      seg3_r <= seg3_nxt;
      seg4_r <= seg4_nxt;
    end
  end

  assign led_digit1 = seg1_r;
  assign led_digit2 = seg2_r;
  assign led_digit3 = seg3_r;
  assign led_digit4 = seg4_r;

endmodule
`default_nettype wire

// ---- iosd_display_chk.sv ----
// port assertions for the i/o status led display
`timescale 1ns/1ps
`default_nettype none
module iosd_display_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0] led_digit1,
  input wire logic [7:0] led_digit2,
  input wire logic [7:0] led_digit3,
  input wire logic [7:0] led_digit4
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic dark;
  logic wr_item;
  assign dark = (led_digit1 | led_digit2 | led_digit3 | led_digit4) == 8'h00;
  assign wr_item = reg_write && reg_addr == iosd_pkg::REG_ITEM;
  a_reset_dark: assert property ($fell(rst) |-> dark)
    else $error("display not dark after reset");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data without a read");
  a_state_code: assert property (reg_read && reg_addr == iosd_pkg::REG_STATE |=> reg_rdata < 32'h0000_0003)
    else $error("state code out of range");
  a_level_dark: assert property (reg_write && reg_addr == iosd_pkg::REG_CTRL &&
    reg_wdata[5:4] != iosd_pkg::LEVEL_FULL |-> ##3 dark) else $error("display lit below full menu");
  a_item_readback: assert property (wr_item && reg_wdata < 32'h0000_0005 ##2
    reg_read && reg_addr == iosd_pkg::REG_ITEM |=> reg_rdata == $past(reg_wdata, 3))
    else $error("item readback wrong");
  a_item_refuse: assert property (wr_item && reg_wdata[2:0] > 3'h4 ##2
    reg_read && reg_addr == iosd_pkg::REG_ITEM |=> reg_rdata[2:0] <= 3'h4) else $error("bad item taken");
  a_cmd_readback: assert property (reg_write && reg_addr == iosd_pkg::REG_CMD ##2
    reg_read && reg_addr == iosd_pkg::REG_CMD |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3))
    else $error("command readback wrong");
  a_dash_all: assert property (led_digit1 == iosd_pkg::SEG_DASH |-> {led_digit4, led_digit3, led_digit2} ==
    {3{iosd_pkg::SEG_DASH}}) else $error("dashes not on all digits");
  a_list_glyph: assert property (led_digit3 == iosd_pkg::SEG_UNDERSCORE |->
    led_digit4 == 8'h66 && led_digit2 == 8'h3f) else $error("list view glyphs wrong");
  c_dash: cover property (led_digit1 == iosd_pkg::SEG_DASH);
  c_list: cover property (led_digit3 == iosd_pkg::SEG_UNDERSCORE);
  c_level: cover property (reg_write && reg_addr == iosd_pkg::REG_CTRL ##3 dark);
endmodule
bind iosd_display iosd_display_chk i_chk (.mclk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .led_digit1, .led_digit2, .led_digit3, .led_digit4);
`default_nettype wire

// ---- iosd_panel_model.sv ----
// keypad, terminal wiring and led monitor reader
`timescale 1ns/1ps
`default_nettype none
module iosd_panel_model (
  input wire logic [6:0] contacts,
  input wire logic [3:0] keys_held,
  input wire logic [7:0] led_digit1,
  input wire logic [7:0] led_digit2,
  input wire logic [7:0] led_digit3,
  input wire logic [7:0] led_digit4,
  output logic [6:0] pins,
  output logic [3:0] keys,
  output logic [15:0] shown_word
);
  // a closed contact or a held key reads high at its pin
  assign pins = contacts;
  assign keys = keys_held;
  // glyph back to nibble, unknown for anything not a hex glyph
  function automatic logic [3:0] nib(input logic [7:0] g);
    case (g)
      8'h3f: nib = 4'h0;
      8'h06: nib = 4'h1;
      8'h5b: nib = 4'h2;
      8'h4f: nib = 4'h3;
      8'h66: nib = 4'h4;
      8'h6d: nib = 4'h5;
      8'h7d: nib = 4'h6;
      8'h07: nib = 4'h7;
      8'h7f: nib = 4'h8;
      8'h6f: nib = 4'h9;
      8'h77: nib = 4'ha;
      8'h7c: nib = 4'hb;
      8'h39: nib = 4'hc;
      8'h5e: nib = 4'hd;
      8'h79: nib = 4'he;
      8'h71: nib = 4'hf;
      default: nib = 4'bxxxx;
    endcase
  endfunction
  assign shown_word = {nib(led_digit4), nib(led_digit3), nib(led_digit2), nib(led_digit1)};
endmodule
`default_nettype wire

// ---- iosd_display_bench.sv ----
// self-checking bench for the i/o status led display
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module iosd_display_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] led_digit1, led_digit2, led_digit3, led_digit4;
  logic [6:0] pins;
  logic [3:0] keys;
  logic [6:0] contacts = 7'h00;
  logic [3:0] keys_held = 4'h0;
  logic [15:0] shown_word;
  logic [15:0] word_set [3] = '{16'h89ab, 16'hcdef, 16'h4567};
  logic [15:0] words [3];
  int fails = 0;
  int cmp_count = 0;
  always #12.5 mclk = ~mclk;
  iosd_display i_dut (.mclk, .rst, .forward_run_input(pins[0]), .reverse_run_input(pins[1]),
    .multipurpose_input_1(pins[2]), .multipurpose_input_2(pins[3]), .multipurpose_input_3(pins[4]),
    .transistor_output(pins[5]), .relay_contact_output(pins[6]), .key_program(keys[0]),
    .key_function(keys[1]), .key_up(keys[2]), .key_down(keys[3]), .voltage_input_word(words[0]),
    .current_input_word(words[1]), .meter_output_word(words[2]), .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .led_digit1, .led_digit2, .led_digit3, .led_digit4);
  iosd_panel_model i_panel (.contacts, .keys_held, .led_digit1, .led_digit2, .led_digit3, .led_digit4,
    .pins, .keys, .shown_word);
  task automatic set_pins(input logic [6:0] v);
    @(posedge mclk);
    contacts <= v;
  endtask
  // a press holds the key long enough to pass the synchroniser
  task automatic press(input int k);
    @(posedge mclk);
    keys_held[k] <= 1'b1;
    repeat (4) @(posedge mclk);
    keys_held[k] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // ------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask
  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic show(input logic [31:0] e);
    settle;
    `CHK("digits", e, {led_digit4, led_digit3, led_digit2, led_digit1})
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out;
  end
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      words[j] <= word_set[j];
    end
    show(32'h0000_0000);
    rd(iosd_pkg::REG_CTRL, 32'h0, "ctrl");
    rd(8'h20, 32'h0, "unmapped");
    press(0);
    rd(iosd_pkg::REG_STATE, 32'h0, "state");
    $display("test reset done");
    wr(iosd_pkg::REG_CTRL, 32'h0000_0020);
    press(0);
    rd(iosd_pkg::REG_STATE, 32'h1, "state");
    for (int n = 1; n <= 5; n++) begin
      press(2);
      settle;
      `CHK("item", 4'(n % 5), shown_word[3:0])
    end
    press(3);
    settle;
    `CHK("item", 4'h4, shown_word[3:0])
    press(2);
    press(1);
    rd(iosd_pkg::REG_STATE, 32'h2, "state");
    $display("test list done");
    show(32'h4040_4040);
    for (int i = 0; i < 5; i++) begin
      set_pins(7'(1 << i));
      show({24'h0, 8'(1 << i)});
    end
    set_pins(7'h21);
    show(32'h0001_0001);
    set_pins(7'h41);
    show(32'h0100_0001);
    set_pins(7'h65);
    wr(iosd_pkg::REG_CTRL, 32'h0000_0021);
    settle;
    `CHK("in word", 16'h0005, shown_word)
    rd(iosd_pkg::REG_IN_WORD, 32'h5, "in word");
    wr(iosd_pkg::REG_CTRL, 32'h0000_0023);
    settle;
    `CHK("out word", 16'h0101, shown_word)
    rd(iosd_pkg::REG_OUT_WORD, 32'h101, "out word");
    $display("test terminals done");
    wr(iosd_pkg::REG_CTRL, 32'h0000_0021);
    wr(iosd_pkg::REG_ITEM, 32'h1);
    wr(iosd_pkg::REG_CMD, 32'h0000_00e1);
    rd(iosd_pkg::REG_CMD, 32'he1, "cmd");
    settle;
    `CHK("comm word", 16'he001, shown_word)
    wr(iosd_pkg::REG_CTRL, 32'h0000_0020);
    show(32'h0101_e001);
    wr(iosd_pkg::REG_CTRL, 32'h0000_0021);
    for (int k = 2; k <= 4; k++) begin
      wr(iosd_pkg::REG_ITEM, 32'(k));
      rd(iosd_pkg::REG_ITEM, 32'(k), "item");
      settle;
      `CHK("reading", word_set[k-2], shown_word)
      @(posedge mclk);
      words[k-2] <= ~word_set[k-2];
      settle;
      `CHK("new reading", ~word_set[k-2], shown_word)
    end
    wr(iosd_pkg::REG_ITEM, 32'h5);
    rd(iosd_pkg::REG_ITEM, 32'h4, "item");
    wr(iosd_pkg::REG_STATE, 32'h0);
    rd(iosd_pkg::REG_STATE, 32'h2, "state");
    $display("test comm done");
    press(1);
    press(0);
    show(32'h0000_0000);
    press(0);
    wr(iosd_pkg::REG_CTRL, 32'h0000_0001);
    show(32'h0000_0000);
    rd(iosd_pkg::REG_STATE, 32'h0, "state");
    $display("test exit done");
    close_out;
  end
endmodule
`default_nettype wire
